// ### common/cct_params.svh
`ifndef CCT_PARAMS_SVH
`define CCT_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register word offsets on the plain register port.
// ----------------------------------------------------------------------------
`define CCT_A_MODE        5'h00
`define CCT_A_CTRL1       5'h01
`define CCT_A_STATUS      5'h02
`define CCT_A_IOC0        5'h03
`define CCT_A_IOC1        5'h04
`define CCT_A_CNT         5'h05
`define CCT_A_GRA         5'h06
`define CCT_A_GRB         5'h07
`define CCT_A_GRC         5'h08
`define CCT_A_GRD         5'h09
`define CCT_A_CTRL2       5'h0A
`define CCT_A_FILT        5'h0B
`define CCT_A_OMASK       5'h0C

// ----------------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------------
`define CCT_MODE_RUN      0
`define CCT_MODE_BUFC     1
`define CCT_MODE_BUFD     2
`define CCT_MODE_SEL_LSB  3
`define CCT_OMASK_CUT_EN  7
`define CCT_FILT_TRIG_EN  4
`define CCT_FILT_CLK_LSB  6
`define CCT_OMASK_RST     8'h0F
`define CCT_CNT_MAX       16'hFFFF

// ----------------------------------------------------------------------------
// Count source codes and edge codes.
// ----------------------------------------------------------------------------
`define CCT_SRC_F1        3'h0
`define CCT_SRC_F2        3'h1
`define CCT_SRC_F4        3'h2
`define CCT_SRC_F8        3'h3
`define CCT_SRC_F32       3'h4
`define CCT_SRC_EXT       3'h5
`define CCT_SRC_FOSC      3'h6
`define CCT_EDGE_RISE     2'h0
`define CCT_EDGE_FALL     2'h1
`define CCT_TEDGE_OFF     2'h0
`define CCT_TEDGE_RISE    2'h1
`define CCT_TEDGE_FALL    2'h2
`define CCT_FCLK_F1       2'h0
`define CCT_FCLK_F8       2'h1
`define CCT_FCLK_F32      2'h2

`endif

// ### common/cct_pkg.sv
package cct_pkg;

    // ------------------------------------------------------------------------
    // Operating modes of the timer.
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        cct_mode_timer   = 2'h0,
        cct_mode_pwm     = 2'h1,
        cct_mode_waitpwm = 2'h2
    } cct_mode_t;

    // Complete state of the timer core.
    typedef struct packed {
        logic [4:0]        presc;
        logic              run;
        logic              buf_c;
        logic              buf_d;
        cct_mode_t         mode;
        logic [2:0]        src;
        logic [4:0]        flags;
        logic [15:0]       ioc;
        logic [15:0]       cnt;
        logic [3:0][15:0]  gr;
        logic [1:0]        tedge;
        logic [7:0]        filt;
        logic [7:0]        omask;
        logic              ext_prev;
        logic              fosc_prev;
        logic [3:0]        ch_prev;
        logic              trig_prev;
        logic [3:0]        pin_out;
        logic [4:0]        evt;
        logic [15:0]       rdata;
    } cct_core_t;

endpackage

// ### common/cct_filt_if.sv
`timescale 1ns/10ps

// Carries raw inputs to the three-sample filter and the settled levels back.
interface cct_filt_if;
    logic [4:0] raw;
    logic [4:0] enable;
    logic       sample_tick;
    logic [4:0] level;

    modport filt
    (
        input  raw,
        input  enable,
        input  sample_tick,
        output level
    );
    modport user
    (
        output raw,
        output enable,
        output sample_tick,
        input  level
    );
endinterface

// ### src/cct_filter.sv
`timescale 1ns/10ps

module cct_filter
(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    cct_filt_if.filt  flt
);

    typedef struct packed {
        logic [4:0][1:0] hist;
        logic [4:0]      level;
    } cct_filt_st_t;

    cct_filt_st_t st_ff;
    cct_filt_st_t nxt_st;
    logic [4:0][1:0] nxt_hist;
    logic [4:0]      nxt_level;

    // ------------------------------------------------------------------------
    // Per enabled input: a level settles only after three equal samples in a row.
    // ------------------------------------------------------------------------
    for (genvar gi = 0; gi < 5; gi++)
    begin : g_in
        // A bypassed input follows the pin with one flop of delay.
        assign nxt_hist[gi] = !flt.enable[gi] ? {2{flt.raw[gi]}} :
                              flt.sample_tick ? {st_ff.hist[gi][0], flt.raw[gi]} :
                              st_ff.hist[gi];
        assign nxt_level[gi] = !flt.enable[gi] ? flt.raw[gi] :
                               (flt.sample_tick && st_ff.hist[gi] == {2{flt.raw[gi]}})
                               ? flt.raw[gi] : st_ff.level[gi];
    end

    // Gather next state.
    always_comb
    begin
        nxt_st       = st_ff;
        nxt_st.hist  = nxt_hist;
        nxt_st.level = nxt_level;
    end

    // State register.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign flt.level = st_ff.level;

    // ------------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------------
    chk_filter_three_match : assert property (@(posedge sys_clk) disable iff (!rst_n)
        (flt.enable[1] && $past(flt.enable[1]) && $changed(st_ff.level[1]))
        |-> ($past(st_ff.hist[1]) == {2{st_ff.level[1]}}))
        else $error("Filter level changed without three equal samples.");

endmodule

// ### src/cct_timer.sv
`timescale 1ns/10ps
`include "cct_params.svh"

// Functional notes
// - Code 110b selects the fast oscillator as count source; codes 000b to 100b divide sys_clk.
// - Code 101b counts rising edges of the external clock pin.
// - Buffer bits make register C buffer A and register D buffer B.
// - Buffered capture first moves A (or B) into its buffer register.
// - Buffered compare match reloads A (or B, outside triggered mode) from its buffer.
// - Triggered mode copies D into B on A match or trigger input.
// - A buffer register matching the counter still sets its channel flag.
// - In buffered capture, a pin C/D edge still sets its flag.
// - Filter accepts a level after three equal samples; enable and clock selectable.
// - Trigger filter acts only in triggered mode with trigger edge enabled.
// - Low cutoff pin with cutoff enabled sets all four output disable bits.
// - Channel pins release to port function within one or two clocks.
// - Cutoff affects only output pins, never capture inputs.
// - A valid edge copies the counter into that channel's register; for C or D only when not buffered.
// - Channel A may capture on the slow oscillator signal instead.
// - Counter runs free over 65,536 counts, started and stopped by run bit.
// - Each capture input selects rising, falling or both edges.
// - Capture and overflow raise requests; counter stays readable and writable.
module cct_timer
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic [3:0]  channel_pin_in,
    output logic      [3:0]  channel_pin_out,
    output logic      [3:0]  channel_pin_oe,
    input  wire logic        external_trigger_pin,
    input  wire logic        external_clock_pin,
    input  wire logic        fast_internal_osc,
    input  wire logic        fast_osc_on,
    input  wire logic        slow_osc_divided,
    input  wire logic        cutoff_interrupt_pin,
    output logic      [4:0]  event_req
);

    // ------------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------------
    cct_pkg::cct_core_t st_ff;
    cct_pkg::cct_core_t nxt_st;
    cct_filt_if         flt ();
    logic               is_timer;
    logic               is_wait;
    logic               ext_tick;
    logic               fosc_tick;
    logic               cnt_tick;
    logic               cnt_wr;
    logic               ovf;
    logic               cutoff_act;
    logic               trig_rise;
    logic               trig_fall;
    logic               trig_evt;
    logic [3:0]         in_lvl;
    logic [3:0]         cap_sel;
    logic [3:0]         cap_evt;
    logic [3:0]         match;
    logic [3:0]         set_flag;

    assign is_timer = (st_ff.mode == cct_pkg::cct_mode_timer);
    assign is_wait  = (st_ff.mode == cct_pkg::cct_mode_waitpwm);
    assign cnt_wr   = reg_wr && (reg_addr == `CCT_A_CNT);

    // ------------------------------------------------------------------------
    // Count source selection.
    // ------------------------------------------------------------------------
    // Pins are synchronous, so one previous sample is enough for edge detection.
    assign ext_tick  = external_clock_pin && !st_ff.ext_prev;
    // The oscillator enable gates its edges so a stopped oscillator never counts.
    assign fosc_tick = fast_osc_on && fast_internal_osc && !st_ff.fosc_prev;

    always_comb
    begin
        case (st_ff.src)
            `CCT_SRC_F1:   cnt_tick = 1'b1;
            `CCT_SRC_F2:   cnt_tick = st_ff.presc[0];
            `CCT_SRC_F4:   cnt_tick = &st_ff.presc[1:0];
            `CCT_SRC_F8:   cnt_tick = &st_ff.presc[2:0];
            `CCT_SRC_F32:  cnt_tick = &st_ff.presc;
            `CCT_SRC_EXT:  cnt_tick = ext_tick;
            `CCT_SRC_FOSC: cnt_tick = fosc_tick;
            default:       cnt_tick = 1'b0;
        endcase
    end

    // Overflow only counts when software is not overwriting the counter.
    assign ovf = st_ff.run && cnt_tick && !cnt_wr && (st_ff.cnt == `CCT_CNT_MAX);

    // ------------------------------------------------------------------------
    // Input filter for the channel pins and the trigger pin.
    // ------------------------------------------------------------------------
    assign flt.raw       = {external_trigger_pin, channel_pin_in};
    assign flt.enable    = {st_ff.filt[`CCT_FILT_TRIG_EN] && is_wait &&
                            (st_ff.tedge != `CCT_TEDGE_OFF), st_ff.filt[3:0]};

    always_comb
    begin
        case (st_ff.filt[`CCT_FILT_CLK_LSB +: 2])
            `CCT_FCLK_F1:  flt.sample_tick = 1'b1;
            `CCT_FCLK_F8:  flt.sample_tick = &st_ff.presc[2:0];
            `CCT_FCLK_F32: flt.sample_tick = &st_ff.presc;
            default:       flt.sample_tick = cnt_tick;
        endcase
    end

    cct_filter u_filter
    (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .flt     (flt)
    );

    // Channel A may take the slow oscillator signal in place of its pin.
    assign in_lvl = {flt.level[3:1], st_ff.ioc[3] ? slow_osc_divided : flt.level[0]};

    // ------------------------------------------------------------------------
    // Per-channel edge detection and compare match.
    // ------------------------------------------------------------------------
    for (genvar gj = 0; gj < 4; gj++)
    begin : g_ch
        logic rise;
        logic fall;
        logic [1:0] esel;
        assign rise         = in_lvl[gj] && !st_ff.ch_prev[gj];
        assign fall         = !in_lvl[gj] && st_ff.ch_prev[gj];
        assign esel         = st_ff.ioc[4*gj +: 2];
        // Capture select only counts in timer mode; other modes compare on all pins.
        assign cap_sel[gj]  = is_timer && st_ff.ioc[4*gj+2];
        assign cap_evt[gj]  = cap_sel[gj] &&
                              ((esel == `CCT_EDGE_RISE) ? rise :
                               (esel == `CCT_EDGE_FALL) ? fall : (rise || fall));
        assign match[gj]    = !cap_sel[gj] && st_ff.run && cnt_tick &&
                              (st_ff.cnt == st_ff.gr[gj]);
        // Only compare-driven pins drive; capture pins are never touched by cutoff.
        assign channel_pin_oe[gj] = !cap_sel[gj] && !st_ff.omask[gj];
    end

    // Flags rise on capture events and on matches, buffered or not.
    assign set_flag = cap_evt | match;

    // ------------------------------------------------------------------------
    // Trigger input and cutoff.
    // ------------------------------------------------------------------------
    assign trig_rise  = flt.level[4] && !st_ff.trig_prev;
    assign trig_fall  = !flt.level[4] && st_ff.trig_prev;
    assign trig_evt   = is_wait && (((st_ff.tedge == `CCT_TEDGE_RISE) && trig_rise) ||
                                    ((st_ff.tedge == `CCT_TEDGE_FALL) && trig_fall) ||
                                    ((st_ff.tedge == 2'h3) && (trig_rise || trig_fall)));
    assign cutoff_act = st_ff.omask[`CCT_OMASK_CUT_EN] && !cutoff_interrupt_pin;

    // ------------------------------------------------------------------------
    // Next state: register writes, counter, capture and buffer transfers.
    // ------------------------------------------------------------------------
    // Hardware transfers win over a software write to the same register in the
    // same cycle, so no capture value is ever lost to a late write.
    always_comb
    begin
        nxt_st           = st_ff;
        nxt_st.presc     = st_ff.presc + 5'h01;
        nxt_st.ext_prev  = external_clock_pin;
        nxt_st.fosc_prev = fast_internal_osc;
        nxt_st.ch_prev   = in_lvl;
        nxt_st.trig_prev = flt.level[4];
        nxt_st.evt       = {ovf, cap_evt | match};
        nxt_st.pin_out   = st_ff.pin_out ^ match;
        nxt_st.rdata     = 16'h0000;
        if (reg_wr)
        begin
            case (reg_addr)
                `CCT_A_MODE:
                begin
                    nxt_st.run   = reg_wdata[`CCT_MODE_RUN];
                    nxt_st.buf_c = reg_wdata[`CCT_MODE_BUFC];
                    nxt_st.buf_d = reg_wdata[`CCT_MODE_BUFD];
                    nxt_st.mode  = cct_pkg::cct_mode_t'(reg_wdata[`CCT_MODE_SEL_LSB +: 2]);
                end
                `CCT_A_CTRL1:  nxt_st.src = reg_wdata[2:0];
                `CCT_A_IOC0:   nxt_st.ioc[7:0] = reg_wdata[7:0];
                `CCT_A_IOC1:   nxt_st.ioc[15:8] = reg_wdata[7:0];
                `CCT_A_GRA:    nxt_st.gr[0] = reg_wdata;
                `CCT_A_GRB:    nxt_st.gr[1] = reg_wdata;
                `CCT_A_GRC:    nxt_st.gr[2] = reg_wdata;
                `CCT_A_GRD:    nxt_st.gr[3] = reg_wdata;
                `CCT_A_CTRL2:  nxt_st.tedge = reg_wdata[1:0];
                `CCT_A_FILT:   nxt_st.filt = reg_wdata[7:0];
                `CCT_A_OMASK:  nxt_st.omask = reg_wdata[7:0];
                default:       nxt_st.presc = nxt_st.presc;
            endcase
        end
        // Writing a zero clears a flag; a new event in the same cycle still sets it.
        nxt_st.flags = (st_ff.flags & ((reg_wr && reg_addr == `CCT_A_STATUS) ?
                        reg_wdata[4:0] : 5'h1F)) | {ovf, set_flag};
        // Software write has priority over counting; free-running wrap at the top.
        if (cnt_wr)
            nxt_st.cnt = reg_wdata;
        else if (st_ff.run && cnt_tick)
            nxt_st.cnt = st_ff.cnt + 16'h0001;
        // Register A: capture, or reload from buffer C on match.
        if (cap_evt[0])
            nxt_st.gr[0] = st_ff.cnt;
        else if (match[0] && st_ff.buf_c)
            nxt_st.gr[0] = st_ff.gr[2];
        // Register C: old A on buffered capture, else its own capture.
        if (cap_evt[0] && st_ff.buf_c)
            nxt_st.gr[2] = st_ff.gr[0];
        else if (cap_evt[2] && !st_ff.buf_c)
            nxt_st.gr[2] = st_ff.cnt;
        // Register B: capture, triggered reload from D, or buffered reload.
        if (cap_evt[1])
            nxt_st.gr[1] = st_ff.cnt;
        else if (is_wait && (match[0] || trig_evt))
            nxt_st.gr[1] = st_ff.gr[3];
        else if (match[1] && st_ff.buf_d && !is_wait)
            nxt_st.gr[1] = st_ff.gr[3];
        // Register D: old B on buffered capture, else its own capture.
        if (cap_evt[1] && st_ff.buf_d)
            nxt_st.gr[3] = st_ff.gr[1];
        else if (cap_evt[3] && !st_ff.buf_d)
            nxt_st.gr[3] = st_ff.cnt;
        // Cutoff forces all disables high and outranks a software clear.
        if (cutoff_act)
            nxt_st.omask[3:0] = 4'hF;
        if (reg_rd)
        begin
            case (reg_addr)
                `CCT_A_MODE:   nxt_st.rdata = {11'h000, st_ff.mode, st_ff.buf_d,
                                               st_ff.buf_c, st_ff.run};
                `CCT_A_CTRL1:  nxt_st.rdata = {13'h0000, st_ff.src};
                `CCT_A_STATUS: nxt_st.rdata = {11'h000, st_ff.flags};
                `CCT_A_IOC0:   nxt_st.rdata = {8'h00, st_ff.ioc[7:0]};
                `CCT_A_IOC1:   nxt_st.rdata = {8'h00, st_ff.ioc[15:8]};
                `CCT_A_CNT:    nxt_st.rdata = st_ff.cnt;
                `CCT_A_GRA:    nxt_st.rdata = st_ff.gr[0];
                `CCT_A_GRB:    nxt_st.rdata = st_ff.gr[1];
                `CCT_A_GRC:    nxt_st.rdata = st_ff.gr[2];
                `CCT_A_GRD:    nxt_st.rdata = st_ff.gr[3];
                `CCT_A_CTRL2:  nxt_st.rdata = {14'h0000, st_ff.tedge};
                `CCT_A_FILT:   nxt_st.rdata = {8'h00, st_ff.filt};
                `CCT_A_OMASK:  nxt_st.rdata = {8'h00, st_ff.omask};
                default:       nxt_st.rdata = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            st_ff       <= '0;
            st_ff.omask <= `CCT_OMASK_RST;
        end
        else
            st_ff <= nxt_st;
    end

    assign reg_rdata       = st_ff.rdata;
    assign channel_pin_out = st_ff.pin_out;
    assign event_req       = st_ff.evt;

    // ------------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    chk_fast_osc_count : assert property (
        (st_ff.src == `CCT_SRC_FOSC && st_ff.run && fast_osc_on && fast_internal_osc &&
         !st_ff.fosc_prev && !cnt_wr) |=> (st_ff.cnt == $past(st_ff.cnt) + 16'h0001))
        else $error("Fast oscillator edge did not advance the counter.");

    chk_ext_clk_count : assert property (
        (st_ff.src == `CCT_SRC_EXT && st_ff.run && !cnt_wr && !ext_tick)
        |=> (st_ff.cnt == $past(st_ff.cnt)))
        else $error("Counter moved without an external clock edge.");

    chk_buffer_capture : assert property (
        (cap_evt[0] && st_ff.buf_c) |=> (st_ff.gr[2] == $past(st_ff.gr[0]) &&
                                         st_ff.gr[0] == $past(st_ff.cnt)))
        else $error("Buffered capture did not move A into C.");

    chk_buffer_reload : assert property (
        (match[1] && st_ff.buf_d && !is_wait && !cap_evt[1])
        |=> (st_ff.gr[1] == $past(st_ff.gr[3])))
        else $error("Compare match did not reload B from D.");

    chk_wait_transfer : assert property (
        (is_wait && trig_evt && !cap_evt[1]) |=> (st_ff.gr[1] == $past(st_ff.gr[3])))
        else $error("Trigger did not copy D into B.");

    chk_buffer_flag : assert property (
        (match[2] && st_ff.buf_c) |=> (st_ff.flags[2] && event_req[2]))
        else $error("Buffer register match did not set its flag.");

    chk_capture_flag : assert property (
        (cap_evt[3] && st_ff.buf_d) |=> (st_ff.flags[3] && (st_ff.gr[3] ==
            ($past(cap_evt[1]) ? $past(st_ff.gr[1]) : $past(st_ff.gr[3])))))
        else $error("Buffered pin D edge handled wrongly.");

    chk_cutoff_sets : assert property (
        cutoff_act |=> (st_ff.omask[3:0] == 4'hF))
        else $error("Cutoff did not set all disable bits.");

    chk_cutoff_release : assert property (
        (cutoff_act && !cap_sel[0]) |-> ##[1:2] !channel_pin_oe[0])
        else $error("Pin A still driven two clocks after cutoff.");

    chk_capture_value : assert property (
        (cap_evt[1] && !is_wait) |=> (st_ff.gr[1] == $past(st_ff.cnt)))
        else $error("Capture did not store the counter.");

    chk_stopped_holds : assert property (
        (!st_ff.run && !cnt_wr) [*2] |=> $stable(st_ff.cnt))
        else $error("Stopped counter changed.");

    chk_overflow_req : assert property (
        ovf |=> (event_req[4] && st_ff.cnt == 16'h0000 && st_ff.flags[4]))
        else $error("Overflow did not wrap and raise a request.");

    cov_buffer_capture : cover property (cap_evt[0] && st_ff.buf_c);
    cov_cutoff         : cover property (cutoff_act ##1 (st_ff.omask[3:0] == 4'hF));
    cov_overflow       : cover property (ovf);
    cov_wait_trigger   : cover property (is_wait && trig_evt);

endmodule

// ### verif/cct_pin_model.sv
`timescale 1ns/10ps

// --------
// Pin-side sources: external count clock and the cutoff line.
// --------
module cct_pin_model
(
    input  wire logic sys_clk,
    input  wire logic clk_go,
    input  wire logic cut_req,
    output logic      external_clock_pin,
    output logic      cutoff_interrupt_pin
);
    logic [2:0] div_ff;

    // Four cycles high, four low; parked low between bursts so no stray edge counts.
    always_ff @(posedge sys_clk)
    begin
        div_ff <= clk_go ? div_ff + 3'h1 : 3'h0;
    end
    assign external_clock_pin   = div_ff[2];
    // The cutoff line is pulled up and pulled low only on request.
    assign cutoff_interrupt_pin = ~cut_req;
endmodule

// ### verif/capture_compare_timer_common_tb_top.sv
`timescale 1ns/10ps
`include "cct_params.svh"

module capture_compare_timer_common_tb_top;
    logic        sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        clk_go = 1'b0, cut_req = 1'b0, trig = 1'b0, osc_on = 1'b0, ext_clk, cut_n;
    logic [4:0]  reg_addr = 5'h00, event_req;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd_v;
    logic [3:0]  pins = 4'h0, pin_oe, pout, pold;
    int          errors = 0, total_checks = 0, cyc = 0, edges = 0, i;

    // --------
    // Clock, timeout and stimulus-side edge count.
    // --------
    always #10 sys_clk = ~sys_clk;
    always @(posedge ext_clk) edges++;
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            errors++;
            report_and_stop();
        end
    end

    cct_timer uut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .channel_pin_in(pins), .channel_pin_out(pout), .channel_pin_oe(pin_oe),
        .external_trigger_pin(trig), .external_clock_pin(ext_clk),
        .fast_internal_osc(ext_clk), .fast_osc_on(osc_on), .slow_osc_divided(1'b0),
        .cutoff_interrupt_pin(cut_n), .event_req(event_req));
    cct_pin_model pm (.sys_clk(sys_clk), .clk_go(clk_go), .cut_req(cut_req),
        .external_clock_pin(ext_clk), .cutoff_interrupt_pin(cut_n));

    // --------
    // Register port tasks; a gap cycle keeps each strobe to one assignment per step.
    // --------
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
    begin
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    end
    endtask

    task automatic rd(input logic [4:0] a);
    begin
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
        @(posedge sys_clk);
    end
    endtask

    task automatic ck(input logic [15:0] got, input logic [15:0] exp);
    begin
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask

    task automatic report_and_stop();
    begin
        $display("errors=%0d total_checks=%0d", errors, total_checks);
        if (errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask

    // --------
    // Main sequence.
    // --------
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rd(`CCT_A_OMASK); ck(rd_v, 16'h000F);
        rd(5'h1F); ck(rd_v, 16'h0000);
        wr(`CCT_A_CNT, 16'h1234); rd(`CCT_A_CNT); ck(rd_v, 16'h1234);
        // Overflow request must arrive within 40 cycles; sixteen counts are left.
        wr(`CCT_A_CNT, 16'hFFF0);
        wr(`CCT_A_MODE, 16'h0001);
        for (i = 0; i < 40 && event_req[4] !== 1'b1; i++) @(negedge sys_clk);
        ck({15'h0000, event_req[4]}, 16'h0001);
        @(posedge sys_clk);
        wr(`CCT_A_MODE, 16'h0000);
        rd(`CCT_A_CNT); ck(rd_v[15:8], 8'h00);
        i = rd_v;
        rd(`CCT_A_CNT); ck(rd_v, i[15:0]);
        // External clock, then the fast oscillator fed with the same wave.
        osc_on <= 1'b1;
        for (i = 5; i < 7; i++)
        begin
            wr(`CCT_A_CTRL1, i[15:0]);
            wr(`CCT_A_CNT, 16'h0000);
            wr(`CCT_A_MODE, 16'h0001);
            edges = 0;
            clk_go <= 1'b1;
            repeat (80) @(posedge sys_clk);
            clk_go <= 1'b0;
            repeat (10) @(posedge sys_clk);
            wr(`CCT_A_MODE, 16'h0000);
            rd(`CCT_A_CNT); ck(rd_v, edges[15:0]);
        end
        // Buffered rising-edge capture on channel A with the counter parked.
        wr(`CCT_A_CTRL1, 16'h0000);
        wr(`CCT_A_IOC0, 16'h0004);
        wr(`CCT_A_IOC1, 16'h0004);
        wr(`CCT_A_MODE, 16'h0002);
        wr(`CCT_A_CNT, 16'h0100);
        pins <= 4'h1;
        repeat (5) @(posedge sys_clk);
        rd(`CCT_A_GRA); ck(rd_v, 16'h0100);
        pins <= 4'h0;
        repeat (5) @(posedge sys_clk);
        wr(`CCT_A_CNT, 16'h0200);
        rd(`CCT_A_GRA); ck(rd_v, 16'h0100);
        pins <= 4'h1;
        repeat (5) @(posedge sys_clk);
        rd(`CCT_A_GRA); ck(rd_v, 16'h0200);
        rd(`CCT_A_GRC); ck(rd_v, 16'h0100);
        // Forced cutoff from the interrupt pin in pulse mode.
        wr(`CCT_A_IOC0, 16'h0000);
        wr(`CCT_A_IOC1, 16'h0000);
        wr(`CCT_A_MODE, 16'h0008);
        wr(`CCT_A_OMASK, 16'h0080);
        ck({12'h000, pin_oe}, 16'h000F);
        cut_req <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 ck({12'h000, pin_oe}, 16'h0000);
        rd(`CCT_A_OMASK); ck(rd_v, 16'h008F);
        cut_req <= 1'b0;
        wr(`CCT_A_OMASK, 16'h0080);
        ck({12'h000, pin_oe}, 16'h000F);
        // Buffered compare in pulse mode: B reloads from D, buffer C still flags.
        wr(`CCT_A_GRB, 16'h0310);
        wr(`CCT_A_GRC, 16'h0320);
        wr(`CCT_A_GRD, 16'h0400);
        wr(`CCT_A_CNT, 16'h0300);
        wr(`CCT_A_STATUS, 16'h0000);
        pold = pout;
        wr(`CCT_A_MODE, 16'h000F);
        repeat (40) @(posedge sys_clk);
        wr(`CCT_A_MODE, 16'h0000);
        rd(`CCT_A_GRB); ck(rd_v, 16'h0400);
        rd(`CCT_A_STATUS); ck(rd_v, 16'h0006);
        ck({12'h000, pout ^ pold}, 16'h0006);
        // Triggered mode: a rising trigger copies D into B.
        wr(`CCT_A_CTRL2, 16'h0001);
        wr(`CCT_A_GRD, 16'h0777);
        wr(`CCT_A_MODE, 16'h0010);
        trig <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(`CCT_A_GRB); ck(rd_v, 16'h0777);
        trig <= 1'b0;
        // Filtered capture on B: a two-sample glitch is ignored, a steady level is not.
        wr(`CCT_A_MODE, 16'h0000);
        wr(`CCT_A_IOC0, 16'h0040);
        wr(`CCT_A_FILT, 16'h0002);
        wr(`CCT_A_CNT, 16'h0500);
        pins <= 4'h2;
        repeat (2) @(posedge sys_clk);
        pins <= 4'h0;
        repeat (4) @(posedge sys_clk);
        rd(`CCT_A_GRB); ck(rd_v, 16'h0777);
        pins <= 4'h2;
        repeat (6) @(posedge sys_clk);
        rd(`CCT_A_GRB); ck(rd_v, 16'h0500);
        report_and_stop();
    end
endmodule
